// >>> logic/mda_top.sv
// Purpose: Data-space address generation and decode for the MPU core:
//          paged and pointer-based external data addresses, dual data
//          pointer, 256-byte internal data space and its function
//          registers.
// Assumes: Core issues at most one internal access (byte or bit) per
//          cycle; a byte access wins over a bit access.
// Notes:   Read data and external address appear one cycle after the
//          request. Unimplemented function registers read as zero.
`timescale 1ns/100ps
module mda_top (
    input  wire logic               MCLK,
    input  wire logic               NRST,
    input  wire mda_pkg::mda_iacc_t IDATA_ACC,
    input  wire mda_pkg::mda_bacc_t BIT_ACC,
    input  wire mda_pkg::mda_xreq_t XDATA_REQ,
    input  wire mda_pkg::mda_ptrop_t PTR_OP,
    output logic [7:0]              IDATA_RDATA,
    output logic                    BIT_RDATA,
    output logic [15:0]             XADDR,
    output logic                    XDATA_STB,
    output logic                    XDATA_WE,
    output logic [15:0]             ACTIVE_PTR,
    output logic [1:0]              BANK_SEL
);

    ////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Byte address of a working register in the given bank
    function automatic logic [7:0] bank_addr(input logic [1:0] bank,
                                             input logic [2:0] rnum);
        bank_addr = {3'h0, bank, rnum};
    endfunction

    // Byte holding a given bit address
    function automatic logic [7:0] bit_byte(input logic [7:0] baddr);
        if (baddr[mda_pkg::UPPER_BIT]) begin
            bit_byte = {baddr[7:3], mda_pkg::BIT_SFR_LOW};
        end else begin
            bit_byte = mda_pkg::BIT_AREA | {4'h0, baddr[6:3]};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // State

    logic [15:0] ptr [2];
    logic        sel;
    logic [7:0]  xpage;
    logic [7:0]  program_status_word;

    logic [1:0]  bank;
    logic [7:0]  eff;
    logic        idata_act;
    logic        bit_act;
    logic        bit_rd_act;
    logic        bit_wr_act;
    logic        to_sfr;
    logic        to_hi_ram;
    logic [7:0]  bbyte;
    logic [2:0]  bidx;
    logic [7:0]  sfr_addr;
    logic [7:0]  sfr_rdata;
    logic        sfr_we;
    logic [7:0]  sfr_wdata;
    logic [7:0]  bit_new;
    logic [7:0]  lo_rdata;
    logic [7:0]  lo_idx;
    logic [7:0]  hi_rdata;
    logic        lo_we;
    logic [6:0]  lo_addr;
    logic [7:0]  lo_wdata;
    logic        hi_we;
    logic [7:0]  idx_addr;

    assign bank     = program_status_word[mda_pkg::BANK_MSB:mda_pkg::BANK_LSB];
    assign BANK_SEL = bank;

    ////////////////////////////////////////////////////////////////////
    // Internal address decode

    assign idata_act  = IDATA_ACC.rd | IDATA_ACC.wr;
    assign bit_act    = (BIT_ACC.rd | BIT_ACC.wr) & ~idata_act;
    assign bit_rd_act = bit_act & BIT_ACC.rd;
    assign bit_wr_act = bit_act & BIT_ACC.wr;

    // Register operands map into the current bank
    assign eff = IDATA_ACC.reg_op ?
                 bank_addr(bank, IDATA_ACC.addr[2:0]) :
                 IDATA_ACC.addr;

    // Upper half splits by mode; the lower half is one RAM for both
    assign to_sfr    = eff[mda_pkg::UPPER_BIT] & ~IDATA_ACC.ind;
    assign to_hi_ram = eff[mda_pkg::UPPER_BIT] & IDATA_ACC.ind;

    assign bbyte    = bit_byte(BIT_ACC.addr);
    assign bidx     = BIT_ACC.addr[mda_pkg::BIT_IDX_W-1:0];
    assign sfr_addr = idata_act ? eff : bbyte;

    // Function-register read mux
    always_comb begin
        if (sfr_addr == mda_pkg::SFR_PTR_LO) begin
            sfr_rdata = ptr[0][7:0];
        end else if (sfr_addr == mda_pkg::SFR_PTR_HI) begin
            sfr_rdata = ptr[0][15:8];
        end else if (sfr_addr == mda_pkg::SFR_PTR2_LO) begin
            sfr_rdata = ptr[1][7:0];
        end else if (sfr_addr == mda_pkg::SFR_PTR2_HI) begin
            sfr_rdata = ptr[1][15:8];
        end else if (sfr_addr == mda_pkg::SFR_PTR_SEL) begin
            sfr_rdata = {7'h00, sel};
        end else if (sfr_addr == mda_pkg::SFR_XPAGE) begin
            sfr_rdata = xpage;
        end else if (sfr_addr == mda_pkg::SFR_PSW) begin
            sfr_rdata = program_status_word;
        end else begin
            sfr_rdata = mda_pkg::UNIMPL_DATA;
        end
    end

    // Bit writes are a read-modify-write of the holding byte
    always_comb begin
        bit_new = bit_wr_act & BIT_ACC.addr[mda_pkg::UPPER_BIT] ?
                  sfr_rdata : lo_rdata;
        bit_new[bidx] = BIT_ACC.val;
    end

    assign sfr_we = (IDATA_ACC.wr & to_sfr) |
                    (bit_wr_act & BIT_ACC.addr[mda_pkg::UPPER_BIT]);
    assign sfr_wdata = idata_act ? IDATA_ACC.wdata : bit_new;

    ////////////////////////////////////////////////////////////////////
    // Internal RAM halves

    assign lo_we = (IDATA_ACC.wr & ~eff[mda_pkg::UPPER_BIT]) |
                   (bit_wr_act & ~BIT_ACC.addr[mda_pkg::UPPER_BIT]);
    assign lo_addr  = idata_act ? eff[6:0] : bbyte[6:0];
    assign lo_wdata = idata_act ? IDATA_ACC.wdata : bit_new;
    assign hi_we    = IDATA_ACC.wr & to_hi_ram;

    // Index register of the bank in force this cycle
    assign idx_addr = bank_addr(bank, {2'h0, XDATA_REQ.ri});

    mda_iram #(
        .DEPTH (mda_pkg::HALF_DEPTH),
        .AW    (mda_pkg::HALF_AW)
    ) u_lo_ram (
        .clk     (MCLK),
        .we      (lo_we),
        .waddr   (lo_addr),
        .wdata   (lo_wdata),
        .raddr_a (lo_addr),
        .rdata_a (lo_rdata),
        .raddr_b (idx_addr[6:0]),
        .rdata_b (lo_idx)
    );

    mda_iram #(
        .DEPTH (mda_pkg::HALF_DEPTH),
        .AW    (mda_pkg::HALF_AW)
    ) u_hi_ram (
        .clk     (MCLK),
        .we      (hi_we),
        .waddr   (eff[6:0]),
        .wdata   (IDATA_ACC.wdata),
        .raddr_a (eff[6:0]),
        .rdata_a (hi_rdata),
        .raddr_b (eff[6:0]),
        .rdata_b ()
    );

    ////////////////////////////////////////////////////////////////////
    // Data pointers

    // A byte write to a pointer's own register bytes wins over a pointer
    // operation on it in the same cycle; the core never issues both.
    for (genvar g = 0; g < 2; g++) begin : g_ptr
        localparam logic [7:0] LO_A = g == 0 ? mda_pkg::SFR_PTR_LO :
                                               mda_pkg::SFR_PTR2_LO;
        localparam logic [7:0] HI_A = g == 0 ? mda_pkg::SFR_PTR_HI :
                                               mda_pkg::SFR_PTR2_HI;
        localparam logic       ME   = (g != 0);
        always_ff @(posedge MCLK or negedge NRST) begin
            if (!NRST) begin
                ptr[g] <= mda_pkg::RST_PTR;
            end else if (sfr_we && sfr_addr == LO_A) begin
                ptr[g][7:0] <= sfr_wdata;
            end else if (sfr_we && sfr_addr == HI_A) begin
                ptr[g][15:8] <= sfr_wdata;
            end else if (PTR_OP.load && sel == ME) begin
                ptr[g] <= PTR_OP.value;
            end else if (PTR_OP.inc && sel == ME) begin
                ptr[g] <= ptr[g] + mda_pkg::PTR_STEP;
            end
        end
    end

    // Only the select bit is stored; the others read as zero
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            sel <= mda_pkg::RST_BYTE[mda_pkg::SEL_BIT];
        end else if (sfr_we && sfr_addr == mda_pkg::SFR_PTR_SEL) begin
            sel <= sfr_wdata[mda_pkg::SEL_BIT];
        end
    end

    assign ACTIVE_PTR = sel ? ptr[1] : ptr[0];

    ////////////////////////////////////////////////////////////////////
    // Page and status registers

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            xpage <= mda_pkg::RST_BYTE;
        end else if (sfr_we && sfr_addr == mda_pkg::SFR_XPAGE) begin
            xpage <= sfr_wdata;
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            program_status_word <= mda_pkg::RST_BYTE;
        end else if (sfr_we && sfr_addr == mda_pkg::SFR_PSW) begin
            program_status_word <= sfr_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            IDATA_RDATA <= mda_pkg::RST_BYTE;
        end else if (IDATA_ACC.rd) begin
            if (to_sfr) begin
                IDATA_RDATA <= sfr_rdata;
            end else if (to_hi_ram) begin
                IDATA_RDATA <= hi_rdata;
            end else begin
                IDATA_RDATA <= lo_rdata;
            end
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            BIT_RDATA <= 1'b0;
        end else if (bit_rd_act) begin
            BIT_RDATA <= BIT_ACC.addr[mda_pkg::UPPER_BIT] ?
                         sfr_rdata[bidx] : lo_rdata[bidx];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // External data address
    // Both paths may be used back to back; each request stands alone.

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            XADDR <= mda_pkg::RST_PTR;
        end else if (XDATA_REQ.req && XDATA_REQ.paged) begin
            XADDR <= {xpage, lo_idx};
        end else if (XDATA_REQ.req) begin
            XADDR <= ACTIVE_PTR;
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            XDATA_STB <= 1'b0;
            XDATA_WE  <= 1'b0;
        end else begin
            XDATA_STB <= XDATA_REQ.req;
            XDATA_WE  <= XDATA_REQ.req & XDATA_REQ.we;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);

    sequence bit_write_s;
        bit_wr_act && !BIT_ACC.addr[mda_pkg::UPPER_BIT];
    endsequence

    sequence bit_reread_s;
        bit_rd_act && BIT_ACC.addr == $past(BIT_ACC.addr);
    endsequence

    paged_low_a: assert property (
        XDATA_REQ.req && XDATA_REQ.paged |=> XADDR[7:0] == $past(lo_idx))
        else $error("paged low byte wrong");

    paged_high_a: assert property (
        XDATA_REQ.req && XDATA_REQ.paged |=> XADDR[15:8] == $past(xpage))
        else $error("paged high byte wrong");

    page_write_a: assert property (
        IDATA_ACC.wr && !IDATA_ACC.ind && !IDATA_ACC.reg_op &&
        IDATA_ACC.addr == mda_pkg::SFR_XPAGE
        |=> xpage == $past(IDATA_ACC.wdata))
        else $error("page register not written");

    ptr_addr_a: assert property (
        XDATA_REQ.req && !XDATA_REQ.paged
        |=> XADDR == (($past(sel)) ? $past(ptr[1]) : $past(ptr[0])))
        else $error("pointer address wrong");

    select_keep_a: assert property (
        sfr_we && sfr_addr == mda_pkg::SFR_PTR_SEL
        |=> $stable(ptr[0]) && $stable(ptr[1]))
        else $error("select change moved a pointer");

    inc_other_a: assert property (
        PTR_OP.inc && !PTR_OP.load && !sfr_we && !sel
        |=> ptr[0] == $past(ptr[0]) + mda_pkg::PTR_STEP &&
            $stable(ptr[1]) ##1 ACTIVE_PTR == $past(ptr[0]) || sel)
        else $error("increment hit wrong pointer");

    direct_sfr_a: assert property (
        IDATA_ACC.rd && !IDATA_ACC.ind && !IDATA_ACC.reg_op &&
        IDATA_ACC.addr == mda_pkg::SFR_PTR_LO
        |=> IDATA_RDATA == $past(ptr[0][7:0]))
        else $error("direct read missed register");

    indirect_ram_a: assert property (
        IDATA_ACC.wr && IDATA_ACC.ind && IDATA_ACC.addr[7]
        |=> $stable(program_status_word) && $stable(xpage) && $stable(sel))
        else $error("indirect write reached registers");

    bit_area_a: assert property (
        bit_write_s ##1 bit_reread_s
        |=> BIT_RDATA == $past(BIT_ACC.val, 2))
        else $error("bit readback differs");

    unimpl_a: assert property (
        IDATA_ACC.wr && to_sfr && eff == mda_pkg::BIT_AREA + 8'h80
        |=> $stable(program_status_word) && $stable(xpage) && $stable(ptr[0]))
        else $error("unimplemented write changed state");

endmodule

// >>> logic/mda_pkg.sv
// Purpose: Shared constants and carrier types for the MPU data-space
//          address generation and decode block.
// Assumes: One core request of each kind per MCLK cycle.
// Notes:   Function-register addresses are byte addresses in the
//          upper half of the 256-byte internal data space.
package mda_pkg;

    ////////////////////////////////////////////////////////////////////
    // Function-register addresses held by this block
    localparam logic [7:0] SFR_PTR_LO   = 8'h82;
    localparam logic [7:0] SFR_PTR_HI   = 8'h83;
    localparam logic [7:0] SFR_PTR2_LO  = 8'h84;
    localparam logic [7:0] SFR_PTR2_HI  = 8'h85;
    localparam logic [7:0] SFR_PTR_SEL  = 8'h92;
    localparam logic [7:0] SFR_XPAGE    = 8'hbf;
    localparam logic [7:0] SFR_PSW      = 8'hd0;

    ////////////////////////////////////////////////////////////////////
    // Reset values and field positions
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [15:0] RST_PTR      = 16'h0000;
    localparam logic [7:0]  UNIMPL_DATA  = 8'h00;
    localparam int          UPPER_BIT    = 7;
    localparam int          SEL_BIT      = 0;
    localparam int          BANK_LSB     = 3;
    localparam int          BANK_MSB     = 4;
    localparam int          BIT_IDX_W    = 3;
    localparam logic [7:0]  BIT_AREA     = 8'h20;
    localparam logic [2:0]  BIT_SFR_LOW  = 3'h0;
    localparam logic [15:0] PTR_STEP     = 16'h0001;
    localparam int          HALF_DEPTH   = 128;
    localparam int          HALF_AW      = 7;

    ////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       ind;
        logic       reg_op;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mda_iacc_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       val;
        logic [7:0] addr;
    } mda_bacc_t;

    typedef struct packed {
        logic req;
        logic paged;
        logic ri;
        logic we;
    } mda_xreq_t;

    typedef struct packed {
        logic        load;
        logic        inc;
        logic [15:0] value;
    } mda_ptrop_t;

endpackage

// >>> logic/mda_iram.sv
// Purpose: 128-byte internal data RAM half with one write port and two
//          combinational read ports.
// Assumes: Write is synchronous; reads see the stored array contents.
// Notes:   No reset on the array, as for real RAM.
`timescale 1ns/100ps
module mda_iram #(
    parameter int DEPTH = mda_pkg::HALF_DEPTH,
    parameter int AW    = mda_pkg::HALF_AW
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    input  wire logic [AW-1:0] raddr_a,
    output logic      [7:0]    rdata_a,
    input  wire logic [AW-1:0] raddr_b,
    output logic      [7:0]    rdata_b
);

    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata_a = mem[raddr_a];
    assign rdata_b = mem[raddr_b];

endmodule

// >>> sim/mda_core_model.sv
// Purpose: Model of the MPU core issuing data-space requests.
// Assumes: Requests change only at falling edges of the clock.
// Notes:   One request kind per cycle; kind 0 with no flags is idle.
`timescale 1ns/100ps
module mda_core_model (
    input  wire logic           clk,
    output mda_pkg::mda_iacc_t  iacc,
    output mda_pkg::mda_bacc_t  bacc,
    output mda_pkg::mda_xreq_t  xreq,
    output mda_pkg::mda_ptrop_t ptrop
);

    initial begin
        iacc  = '0;
        bacc  = '0;
        xreq  = '0;
        ptrop = '0;
    end

    ////////////////////////////////////////////////////////////////////
    // Kind: 0 byte, 1 bit, 2 external, 3 pointer. Flags per kind:
    // byte {rd,wr,ind,reg_op}, bit {rd,wr,val,-}, external {-,paged,ri,we},
    // pointer {-,-,load,inc}.
    // All four carriers change in one step so the core never shows a
    // half-updated mix of an old and a new request.
    task automatic issue(
        input logic [1:0]  kind,
        input logic [3:0]  flags,
        input logic [7:0]  addr,
        input logic [15:0] data
    );
        mda_pkg::mda_iacc_t  ia;
        mda_pkg::mda_bacc_t  ba;
        mda_pkg::mda_xreq_t  xr;
        mda_pkg::mda_ptrop_t po;
        ia = '0;
        ba = '0;
        xr = '0;
        po = '0;
        if (kind == 2'h0) ia = {flags, addr, data[7:0]};
        if (kind == 2'h1) ba = {flags[3:1], addr};
        if (kind == 2'h2) xr = {1'b1, flags[2:0]};
        if (kind == 2'h3) po = {flags[1:0], data};
        @(negedge clk);
        iacc  = ia;
        bacc  = ba;
        xreq  = xr;
        ptrop = po;
    endtask

endmodule

// >>> sim/tb.sv
// Purpose: Self-checking bench for the data-space decode block.
// Assumes: Core model drives one request a cycle at falling edges.
// Notes:   Rows run in order; later rows lean on state left by earlier ones.
`timescale 1ns/100ps
module tb;

    typedef struct {
        logic [1:0]  kind;
        logic [3:0]  flags;
        logic [7:0]  addr;
        logic [15:0] data;
        int          pick;
        logic [15:0] expv;
    } mda_row_t;

    logic                mclk;
    logic                nrst;
    mda_pkg::mda_iacc_t  iacc;
    mda_pkg::mda_bacc_t  bacc;
    mda_pkg::mda_xreq_t  xreq;
    mda_pkg::mda_ptrop_t ptrop;
    logic [7:0]          idata_rdata;
    logic                bit_rdata;
    logic [15:0]         xaddr;
    logic                xdata_stb;
    logic                xdata_we;
    logic [15:0]         active_ptr;
    logic [1:0]          bank_sel;
    int                  fails;
    int                  cmp_count;
    int                  cycles;

    `define MDA_CHK(got, exp) \
        begin \
            cmp_count++; \
            if ((got) !== (exp)) begin \
                fails++; \
                $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
            end \
        end

    ////////////////////////////////////////////////////////////////////
    mda_top dut_u (
        .MCLK        (mclk),
        .NRST        (nrst),
        .IDATA_ACC   (iacc),
        .BIT_ACC     (bacc),
        .XDATA_REQ   (xreq),
        .PTR_OP      (ptrop),
        .IDATA_RDATA (idata_rdata),
        .BIT_RDATA   (bit_rdata),
        .XADDR       (xaddr),
        .XDATA_STB   (xdata_stb),
        .XDATA_WE    (xdata_we),
        .ACTIVE_PTR  (active_ptr),
        .BANK_SEL    (bank_sel)
    );

    mda_core_model core_u (
        .clk   (mclk),
        .iacc  (iacc),
        .bacc  (bacc),
        .xreq  (xreq),
        .ptrop (ptrop)
    );

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////
    // Pick codes: 1 byte read, 2 bit read, 3 address, 4 pointer, 5 bank
    mda_row_t rows [$] = '{
        '{2'h0, 4'h4, 8'h82, 16'h0034, 4, 16'h0034},
        '{2'h0, 4'h4, 8'h83, 16'h0012, 4, 16'h1234},
        '{2'h0, 4'h4, 8'h84, 16'h0078, 4, 16'h1234},
        '{2'h0, 4'h4, 8'h85, 16'h0056, 4, 16'h1234},
        '{2'h0, 4'h4, 8'h92, 16'h0001, 4, 16'h5678},
        '{2'h0, 4'h8, 8'h83, 16'h0000, 1, 16'h0012},
        '{2'h3, 4'h1, 8'h00, 16'h0000, 4, 16'h5679},
        '{2'h0, 4'h8, 8'h82, 16'h0000, 1, 16'h0034},
        '{2'h0, 4'h4, 8'h92, 16'h0000, 4, 16'h1234},
        '{2'h0, 4'h8, 8'h84, 16'h0000, 1, 16'h0079},
        '{2'h3, 4'h2, 8'h00, 16'hffff, 4, 16'hffff},
        '{2'h3, 4'h1, 8'h00, 16'h0000, 4, 16'h0000},
        '{2'h0, 4'h4, 8'hd0, 16'h0010, 5, 16'h0002},
        '{2'h0, 4'h5, 8'h00, 16'h0040, 0, 16'h0000},
        '{2'h0, 4'h5, 8'h01, 16'h0041, 0, 16'h0000},
        '{2'h0, 4'h8, 8'h10, 16'h0000, 1, 16'h0040},
        '{2'h0, 4'ha, 8'h11, 16'h0000, 1, 16'h0041},
        '{2'h0, 4'h4, 8'hbf, 16'h009a, 0, 16'h0000},
        '{2'h2, 4'h4, 8'h00, 16'h0000, 3, 16'h9a40},
        '{2'h2, 4'h7, 8'h00, 16'h0000, 3, 16'h9a41},
        '{2'h3, 4'h2, 8'h00, 16'hbeef, 4, 16'hbeef},
        '{2'h2, 4'h0, 8'h00, 16'h0000, 3, 16'hbeef},
        '{2'h2, 4'h6, 8'h00, 16'h0000, 3, 16'h9a41},
        '{2'h0, 4'h6, 8'h90, 16'h005a, 0, 16'h0000},
        '{2'h0, 4'h8, 8'h90, 16'h0000, 1, 16'h0000},
        '{2'h0, 4'h4, 8'h90, 16'h00a5, 0, 16'h0000},
        '{2'h0, 4'ha, 8'h90, 16'h0000, 1, 16'h005a},
        '{2'h0, 4'h6, 8'hbf, 16'h0011, 0, 16'h0000},
        '{2'h0, 4'h8, 8'hbf, 16'h0000, 1, 16'h009a},
        '{2'h0, 4'ha, 8'hbf, 16'h0000, 1, 16'h0011},
        '{2'h0, 4'h6, 8'hff, 16'h00c3, 0, 16'h0000},
        '{2'h0, 4'ha, 8'hff, 16'h0000, 1, 16'h00c3},
        '{2'h0, 4'h4, 8'h20, 16'h0000, 0, 16'h0000},
        '{2'h1, 4'h6, 8'h05, 16'h0000, 0, 16'h0000},
        '{2'h0, 4'h8, 8'h20, 16'h0000, 1, 16'h0020},
        '{2'h1, 4'h8, 8'h05, 16'h0000, 2, 16'h0001},
        '{2'h0, 4'h4, 8'h2f, 16'h0000, 0, 16'h0000},
        '{2'h1, 4'h6, 8'h7f, 16'h0000, 0, 16'h0000},
        '{2'h0, 4'h8, 8'h2f, 16'h0000, 1, 16'h0080},
        '{2'h1, 4'h6, 8'hd3, 16'h0000, 5, 16'h0003},
        '{2'h1, 4'h8, 8'hd4, 16'h0000, 2, 16'h0001},
        '{2'h1, 4'h6, 8'h83, 16'h0000, 0, 16'h0000},
        '{2'h0, 4'h8, 8'h83, 16'h0000, 1, 16'h00be},
        '{2'h0, 4'h5, 8'h01, 16'h0077, 0, 16'h0000},
        '{2'h2, 4'h6, 8'h00, 16'h0000, 3, 16'h9a77},
        '{2'h0, 4'h8, 8'h19, 16'h0000, 1, 16'h0077},
        '{2'h0, 4'ha, 8'h11, 16'h0000, 1, 16'h0041},
        '{2'h0, 4'h4, 8'ha0, 16'h0055, 4, 16'hbeef},
        '{2'h0, 4'h8, 8'ha0, 16'h0000, 1, 16'h0000},
        '{2'h3, 4'h3, 8'h00, 16'h2222, 4, 16'h2222}
    };

    ////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] pick_out(input int code);
        case (code)
            1: return {8'h00, idata_rdata};
            2: return {15'h0, bit_rdata};
            3: return xaddr;
            4: return active_ptr;
            default: return {14'h0, bank_sel};
        endcase
    endfunction

    task automatic wrap_up();
        if (fails == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic idle();
        core_u.issue(2'h0, 4'h0, 8'h00, 16'h0000);
    endtask

    task automatic reset_reads();
        logic [7:0] regs [7];
        regs = '{mda_pkg::SFR_PTR_LO, mda_pkg::SFR_PTR_HI,
                 mda_pkg::SFR_PTR2_LO, mda_pkg::SFR_PTR2_HI,
                 mda_pkg::SFR_PTR_SEL, mda_pkg::SFR_XPAGE, mda_pkg::SFR_PSW};
        foreach (regs[j]) begin
            core_u.issue(2'h0, 4'h8, regs[j], 16'h0000);
            idle();
            `MDA_CHK(idata_rdata, mda_pkg::RST_BYTE)
        end
    endtask

    // Whole run needs well under 400 cycles; a hang stops here
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        nrst = 1'b0;
        fails = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (4) @(negedge mclk);
        `MDA_CHK(active_ptr, mda_pkg::RST_PTR)
        `MDA_CHK(bank_sel, 2'h0)
        repeat (4) @(negedge mclk);
        nrst = 1'b1;
        reset_reads();
        foreach (rows[i]) begin
            core_u.issue(rows[i].kind, rows[i].flags, rows[i].addr,
                         rows[i].data);
            idle();
            `MDA_CHK(xdata_stb, rows[i].kind == 2'h2)
            `MDA_CHK(xdata_we, rows[i].kind == 2'h2 && rows[i].flags[0])
            if (rows[i].pick != 0)
                `MDA_CHK(pick_out(rows[i].pick), rows[i].expv)
        end
        // Bit write straight followed by a read of the same bit
        core_u.issue(2'h1, 4'h4, 8'h05, 16'h0000);
        core_u.issue(2'h1, 4'h8, 8'h05, 16'h0000);
        idle();
        `MDA_CHK(bit_rdata, 1'b0)
        // Back-to-back external requests around a pointer step
        core_u.issue(2'h3, 4'h2, 8'h00, 16'h1000);
        core_u.issue(2'h2, 4'h0, 8'h00, 16'h0000);
        core_u.issue(2'h3, 4'h1, 8'h00, 16'h0000);
        `MDA_CHK(xaddr, 16'h1000)
        `MDA_CHK(xdata_stb, 1'b1)
        core_u.issue(2'h2, 4'h0, 8'h00, 16'h0000);
        `MDA_CHK(xdata_stb, 1'b0)
        idle();
        `MDA_CHK(xaddr, 16'h1001)
        core_u.issue(2'h0, 4'h4, mda_pkg::SFR_PTR_SEL, 16'h0001);
        idle();
        // Second reset in mid-run with pointers, select, page and status registers non-zero
        @(negedge mclk);
        nrst = 1'b0;
        @(negedge mclk);
        `MDA_CHK(active_ptr, mda_pkg::RST_PTR)
        `MDA_CHK(bank_sel, 2'h0)
        `MDA_CHK(xaddr, 16'h0000)
        nrst = 1'b1;
        reset_reads();
        wrap_up();
    end

endmodule
